// file: verilog/daf_pkg.sv
// Shared types, constants and helpers for the data address and flag block
`default_nettype none

package daf_pkg;

    // ----------------------------------------------------------------
    // Widths and fixed addresses
    // ----------------------------------------------------------------
    localparam int unsigned DADDR_W = 12;
    localparam int unsigned PTR_COUNT = 3;
    localparam logic [11:0] FLAG_DADDR = 12'hfd8;
    localparam logic [7:0] ACC_SPLIT = 8'h80;
    localparam logic [7:0] IDX_LIMIT = 8'h5f;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
    localparam logic [1:0] IDX_PTR = 2'h2;

    // ----------------------------------------------------------------
    // Flag register layout
    // ----------------------------------------------------------------
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_DC = 1;
    localparam int unsigned FLG_Z = 2;
    localparam int unsigned FLG_OV = 3;
    localparam int unsigned FLG_N = 4;
    localparam logic [4:0] FLG_RESET = 5'h00;
    localparam logic [4:0] FLG_ARITH = 5'h1f;
    localparam logic [4:0] FLG_LOGIC = 5'h14;
    localparam logic [4:0] FLG_NONE = 5'h00;
    localparam logic [2:0] FLG_UNIMPL = 3'h0;

    // ----------------------------------------------------------------
    // APB register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] REG_FLAGS = 12'h000;
    localparam logic [11:0] REG_BANK = 12'h004;
    localparam logic [11:0] REG_WORK = 12'h008;
    localparam logic [11:0] REG_CFG = 12'h00c;
    localparam logic [11:0] REG_PTR_LO0 = 12'h010;
    localparam logic [11:0] REG_PTR_HI0 = 12'h014;
    localparam logic [11:0] REG_PTR_STEP = 12'h008;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [7:0] WORK_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Operation encoding from the decoder
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DAF_M_INHERENT, DAF_M_LITERAL, DAF_M_DIRECT, DAF_M_MOVE, DAF_M_INDIRECT, DAF_M_JUMP
    } daf_mode_t;

    typedef enum logic [2:0] {
        DAF_A_NONE, DAF_A_ADD, DAF_A_SUB, DAF_A_AND, DAF_A_ROTL, DAF_A_ROTR, DAF_A_PASS
    } daf_alu_t;

    typedef enum logic [2:0] {
        DAF_I_PLAIN, DAF_I_POST_INCREMENT_OPERAND, DAF_I_POST_DECREMENT_OPERAND, DAF_I_PRE_INCREMENT_OPERAND, DAF_I_POINTER_PLUS_WORKING_OPERAND
    } daf_ind_t;

    typedef enum logic [0:0] {
        DAF_S_IDLE, DAF_S_EXEC
    } daf_state_t;

    typedef struct packed {
        daf_mode_t mode;
        daf_alu_t alu;
        daf_ind_t ind;
        logic [1:0] ptr_sel;
        logic access_sel;
        logic dest_sel;
        logic [7:0] file_addr;
        logic [7:0] literal;
        logic [11:0] move_src;
        logic [11:0] move_dst;
        logic [19:0] jump_target;
    } daf_op_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [11:0] daf_add12(input logic [11:0] a, input logic [11:0] b);
        daf_add12 = a + b;
    endfunction : daf_add12

    function automatic logic [11:0] daf_access_map(input logic [7:0] f);
        daf_access_map = (f < ACC_SPLIT) ? {4'h0, f} : {ACC_HIGH_BANK, f};
    endfunction : daf_access_map

endpackage : daf_pkg

`default_nettype wire

// file: verilog/daf_alu.sv
// Arithmetic unit with flag generation
`default_nettype none

module daf_alu (
    // Operation
    input wire daf_pkg::daf_alu_t alu,
    input wire logic [7:0] a,
    input wire logic [7:0] w,
    input wire logic c_in,
    // Result
    output logic [7:0] res,
    output logic [4:0] flags,
    output logic [4:0] mask
);
    import daf_pkg::*;

    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] b;

    always_comb begin
        b = (alu == DAF_A_SUB) ? ~w : w;
        sum = {1'b0, a} + {1'b0, b} + {8'h00, (alu == DAF_A_SUB)};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, (alu == DAF_A_SUB)};
        res = a;
        flags = '0;
        mask = FLG_NONE;
        case (alu)
            DAF_A_ADD, DAF_A_SUB: begin
                res = sum[7:0];
                mask = FLG_ARITH;
                flags[FLG_C] = sum[8];
                flags[FLG_DC] = nib[4];
                flags[FLG_OV] = (a[7] == b[7]) && (sum[7] != a[7]);
            end
            DAF_A_AND: begin
                res = a & w;
                mask = FLG_LOGIC;
            end
            DAF_A_PASS: begin
                mask = FLG_LOGIC;
            end
            DAF_A_ROTL: begin
                res = {a[6:0], c_in};
                mask = FLG_ARITH & ~(5'h1 << FLG_OV);
                flags[FLG_C] = a[7];
                flags[FLG_DC] = a[3];
            end
            DAF_A_ROTR: begin
                res = {c_in, a[7:1]};
                mask = FLG_ARITH & ~(5'h1 << FLG_OV);
                flags[FLG_C] = a[0];
                flags[FLG_DC] = a[4];
            end
            default: begin
                mask = FLG_NONE;
            end
        endcase
        flags[FLG_N] = res[7];
        flags[FLG_Z] = (res == 8'h00);
    end

endmodule : daf_alu

`default_nettype wire

// file: verilog/daf_ptr.sv
// Pointer address and auto-adjust for indirect operands
`default_nettype none

module daf_ptr (
    // Pointer and mode
    input wire logic [11:0] ptr,
    input wire logic [7:0] w,
    input wire daf_pkg::daf_ind_t ind,
    // Access address and next pointer
    output logic [11:0] addr,
    output logic [11:0] ptr_next
);
    import daf_pkg::*;

    logic [11:0] inc;
    logic [11:0] dec;

    always_comb begin
        // Whole 12-bit pair, low-byte rollover carries into high
        inc = daf_add12(ptr, 12'h001);
        dec = daf_add12(ptr, 12'hfff);
        addr = ptr;
        ptr_next = ptr;
        case (ind)
            DAF_I_POST_INCREMENT_OPERAND: ptr_next = inc;
            DAF_I_POST_DECREMENT_OPERAND: ptr_next = dec;
            DAF_I_PRE_INCREMENT_OPERAND: begin
                addr = inc;
                ptr_next = inc;
            end
            DAF_I_POINTER_PLUS_WORKING_OPERAND: addr = daf_add12(ptr, {{4{w[7]}}, w});
            default: addr = ptr;
        endcase
    end

endmodule : daf_ptr

`default_nettype wire

// file: verilog/daf_core.sv
// Data address generation, pointer pairs and ALU flag register
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`default_nettype none

module daf_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoder request
    input wire logic op_valid,
    input wire daf_pkg::daf_op_t op,
    output logic op_ready,
    output logic op_done,
    // Data memory
    output logic mem_rd_en,
    output logic [11:0] mem_rd_addr,
    input wire logic [7:0] mem_rd_data,
    output logic mem_wr_en,
    output logic [11:0] mem_wr_addr,
    output logic [7:0] mem_wr_data,
    // Program flow and visible state
    output logic jump_valid,
    output logic [19:0] jump_target,
    output logic [7:0] work_reg,
    output logic [7:0] flag_reg
);
    import daf_pkg::*;

    typedef struct packed {
        daf_state_t state;
        daf_op_t op;
        logic [4:0] flags;
        logic [3:0] bank;
        logic [7:0] work;
        logic ext;
        logic [2:0][11:0] ptr;
        logic rd_en;
        logic [11:0] rd_addr;
        logic wr_en;
        logic [11:0] wr_addr;
        logic [7:0] wr_data;
        logic done;
        logic jump_valid;
        logic [19:0] jump_target;
        logic [31:0] prdata;
        logic pslverr;
    } daf_regs_t;

    daf_regs_t q;
    daf_regs_t d;

    // ----------------------------------------------------------------
    // Helper units
    // ----------------------------------------------------------------
    logic [11:0] ind_addr;
    logic [11:0] ind_next;
    logic [7:0] operand;
    logic [7:0] alu_res;
    logic [4:0] alu_flags;
    logic [4:0] alu_mask;

    daf_ptr u_ptr (
        .ptr(q.ptr[op.ptr_sel]),
        .w(q.work),
        .ind(op.ind),
        .addr(ind_addr),
        .ptr_next(ind_next)
    );

    daf_alu u_alu (
        .alu(q.op.alu),
        .a(operand),
        .w(q.work),
        .c_in(q.flags[FLG_C]),
        .res(alu_res),
        .flags(alu_flags),
        .mask(alu_mask)
    );

    // ----------------------------------------------------------------
    // Combinational next state
    // ----------------------------------------------------------------
    logic apb_setup;
    logic apb_write;
    logic accept;
    logic exec;
    logic indexed;
    logic to_file;
    logic [11:0] tgt;
    logic [7:0] wval;
    logic [31:0] rd_mux;
    logic hit;

    always_comb begin
        d = q;
        d.wr_en = 1'b0;
        d.done = 1'b0;
        d.jump_valid = 1'b0;
        apb_setup = psel && !penable;
        apb_write = psel && penable && pwrite;
        accept = op_valid && (q.state == DAF_S_IDLE);
        exec = (q.state == DAF_S_EXEC);
        indexed = q.ext && !op.access_sel && (op.file_addr <= IDX_LIMIT);
        operand = (q.op.mode == DAF_M_LITERAL) ? q.op.literal : mem_rd_data;
        if (q.rd_addr == FLAG_DADDR && q.op.mode != DAF_M_LITERAL) begin
            operand = {FLG_UNIMPL, q.flags};
        end
        to_file = 1'b0;
        tgt = q.rd_addr;
        wval = alu_res;

        // Register read decode
        hit = 1'b1;
        rd_mux = 32'h0;
        case (paddr)
            REG_FLAGS: rd_mux = {24'h0, FLG_UNIMPL, q.flags};
            REG_BANK: rd_mux = {28'h0, q.bank};
            REG_WORK: rd_mux = {24'h0, q.work};
            REG_CFG: rd_mux = {31'h0, q.ext};
            default: hit = 1'b0;
        endcase
        for (int i = 0; i < PTR_COUNT; i++) begin
            if (paddr == REG_PTR_LO0 + REG_PTR_STEP * i[11:0]) begin
                rd_mux = {24'h0, q.ptr[i][7:0]};
                hit = 1'b1;
            end
            if (paddr == REG_PTR_HI0 + REG_PTR_STEP * i[11:0]) begin
                rd_mux = {28'h0, q.ptr[i][11:8]};
                hit = 1'b1;
            end
        end
        if (apb_setup) begin
            d.prdata = rd_mux;
            d.pslverr = !hit;
        end

        // Register writes; the core below wins on a same-cycle clash
        if (apb_write) begin
            case (paddr)
                REG_FLAGS: d.flags = pwdata[4:0];
                REG_BANK: d.bank = pwdata[3:0];
                REG_WORK: d.work = pwdata[7:0];
                REG_CFG: d.ext = pwdata[0];
                default: d.ext = q.ext;
            endcase
            for (int i = 0; i < PTR_COUNT; i++) begin
                if (paddr == REG_PTR_LO0 + REG_PTR_STEP * i[11:0]) begin
                    d.ptr[i][7:0] = pwdata[7:0];
                end
                if (paddr == REG_PTR_HI0 + REG_PTR_STEP * i[11:0]) begin
                    d.ptr[i][11:8] = pwdata[3:0];
                end
            end
        end

        case (q.state)
            DAF_S_IDLE: begin
                if (accept) begin
                    d.op = op;
                    d.rd_en = 1'b0;
                    d.state = DAF_S_EXEC;
                    case (op.mode)
                        DAF_M_DIRECT: begin
                            d.rd_en = 1'b1;
                            if (op.access_sel) begin
                                d.rd_addr = {q.bank, op.file_addr};
                            end else if (indexed) begin
                                d.rd_addr = daf_add12(q.ptr[IDX_PTR], {4'h0, op.file_addr});
                            end else begin
                                d.rd_addr = daf_access_map(op.file_addr);
                            end
                        end
                        DAF_M_MOVE: begin
                            d.rd_en = 1'b1;
                            d.rd_addr = op.move_src;
                        end
                        DAF_M_INDIRECT: begin
                            d.rd_en = 1'b1;
                            d.rd_addr = ind_addr;
                            d.ptr[op.ptr_sel] = ind_next;
                        end
                        DAF_M_JUMP: begin
                            d.jump_valid = 1'b1;
                            d.jump_target = op.jump_target;
                            d.done = 1'b1;
                            d.state = DAF_S_IDLE;
                        end
                        DAF_M_LITERAL: d.state = DAF_S_EXEC;
                        default: begin
                            d.done = 1'b1;
                            d.state = DAF_S_IDLE;
                        end
                    endcase
                end
            end
            DAF_S_EXEC: begin
                d.state = DAF_S_IDLE;
                d.rd_en = 1'b0;
                d.done = 1'b1;
                if (q.op.mode == DAF_M_MOVE) begin
                    to_file = 1'b1;
                    tgt = q.op.move_dst;
                    wval = operand;
                end else if (q.op.mode != DAF_M_LITERAL) begin
                    to_file = q.op.dest_sel;
                end
                if (q.op.alu != DAF_A_NONE && !to_file) begin
                    d.work = alu_res;
                end
                d.flags = (q.flags & ~alu_mask) | (alu_flags & alu_mask);
                if (to_file && tgt == FLAG_DADDR) begin
                    // Flag target: the result is dropped when flags change
                    if (alu_mask == FLG_NONE) begin
                        d.flags = wval[4:0];
                    end
                end else if (to_file) begin
                    d.wr_en = 1'b1;
                    d.wr_addr = tgt;
                    d.wr_data = wval;
                end
            end
            default: d.state = DAF_S_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = q.prdata;
    assign pready = penable;
    assign pslverr = q.pslverr && psel && penable;
    assign op_ready = (q.state == DAF_S_IDLE);
    assign op_done = q.done;
    assign mem_rd_en = q.rd_en;
    assign mem_rd_addr = q.rd_addr;
    assign mem_wr_en = q.wr_en;
    assign mem_wr_addr = q.wr_addr;
    assign mem_wr_data = q.wr_data;
    assign jump_valid = q.jump_valid;
    assign jump_target = q.jump_target;
    assign work_reg = q.work;
    assign flag_reg = {FLG_UNIMPL, q.flags};

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_move_take;
        accept && op.mode == DAF_M_MOVE;
    endsequence

    sequence s_move_write(logic [11:0] dst);
        exec ##1 (mem_wr_en && mem_wr_addr == dst);
    endsequence

    AST_FLAG_UPPER_ZERO: assert property (
        apb_setup && paddr == REG_FLAGS |=> prdata[7:5] == 3'h0 && flag_reg[7:5] == 3'h0)
        else $error("flag upper bits not zero");

    AST_NEG_FLAG: assert property (
        exec && alu_mask[FLG_N] |=> flag_reg[FLG_N] == $past(alu_res[7]))
        else $error("negative flag wrong");

    AST_ZERO_FLAG: assert property (
        exec && alu_mask[FLG_Z] |=> flag_reg[FLG_Z] == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong");

    AST_ADD_CARRY: assert property (
        exec && q.op.alu == DAF_A_ADD
        |=> flag_reg[FLG_C] == $past((({1'b0, operand} + {1'b0, q.work}) >> 8) != 9'h0))
        else $error("add carry wrong");

    AST_SUB_NO_BORROW: assert property (
        exec && q.op.alu == DAF_A_SUB && operand >= q.work |=> flag_reg[FLG_C])
        else $error("subtract without borrow cleared carry");

    AST_BANKED_ADDR: assert property (
        accept && op.mode == DAF_M_DIRECT && op.access_sel
        |=> mem_rd_en && mem_rd_addr == {$past(q.bank), $past(op.file_addr)})
        else $error("banked address wrong");

    AST_ACCESS_BANK: assert property (
        accept && op.mode == DAF_M_DIRECT && !op.access_sel && !indexed
        |=> mem_rd_addr == (($past(op.file_addr) < ACC_SPLIT) ? {4'h0, $past(op.file_addr)}
        : {ACC_HIGH_BANK, $past(op.file_addr)}))
        else $error("access bank address wrong");

    AST_MOVE_ADDRS: assert property (
        s_move_take |=> (mem_rd_addr == $past(op.move_src)
        ##0 s_move_write($past(op.move_dst, 2)))
        or (exec ##1 $past(q.op.move_dst) == FLAG_DADDR))
        else $error("move addresses wrong");

    AST_POST_INCREMENT_OPERAND_STEP: assert property (
        accept && op.mode == DAF_M_INDIRECT && op.ind == DAF_I_POST_INCREMENT_OPERAND
        |=> q.ptr[$past(op.ptr_sel)] == $past(q.ptr[op.ptr_sel]) + 12'h001
        && mem_rd_addr == $past(q.ptr[op.ptr_sel]) && flag_reg == $past(flag_reg))
        else $error("post-increment pointer wrong");

    AST_FLAG_DEST_NO_WRITE: assert property (
        exec && q.op.dest_sel && q.rd_addr == FLAG_DADDR && q.op.mode == DAF_M_DIRECT
        |=> !mem_wr_en)
        else $error("flag register written to memory");

endmodule : daf_core

`default_nettype wire

// file: testbench/daf_mem.sv
// Data memory model on the far side of the block
`default_nettype none

module daf_mem (
    // Clock
    input wire logic sys_clk,
    // Read port
    input wire logic rd_en,
    input wire logic [11:0] rd_addr,
    output logic [7:0] rd_data,
    // Write port
    input wire logic wr_en,
    input wire logic [11:0] wr_addr,
    input wire logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4096];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0];
        end
    end
    // Idle port shows inverted data, so a stale read never matches
    assign rd_data = rd_en ? mem[rd_addr] : ~mem[rd_addr];
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule : daf_mem

`default_nettype wire

// file: testbench/tb_daf_core.sv
// Self-checking bench for the data address and flag block
`default_nettype none

module tb_daf_core;
    timeunit 1ns;
    timeprecision 1ps;
    import daf_pkg::*;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic op_valid, op_ready, op_done, rd_en, wr_en, jump_valid, rerr;
    daf_op_t op, o;
    logic [11:0] rd_addr, wr_addr, rd_a, wr_a;
    logic [7:0] rd_data, wr_data, wr_d, work_reg, flag_reg;
    logic [19:0] jump_target, jt;
    int fails, checks, cyc, rd_n, wr_n;
    daf_ind_t inds [5] = '{DAF_I_POST_INCREMENT_OPERAND, DAF_I_PRE_INCREMENT_OPERAND, DAF_I_POST_DECREMENT_OPERAND, DAF_I_POINTER_PLUS_WORKING_OPERAND, DAF_I_PLAIN};
    logic [11:0] adrs [5] = '{12'h0ff, 12'h101, 12'h101, 12'h0ff, 12'h100};

    daf_core u_daf_core (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_valid(op_valid), .op(op), .op_ready(op_ready),
        .op_done(op_done), .mem_rd_en(rd_en), .mem_rd_addr(rd_addr), .mem_rd_data(rd_data),
        .mem_wr_en(wr_en), .mem_wr_addr(wr_addr), .mem_wr_data(wr_data),
        .jump_valid(jump_valid), .jump_target(jump_target), .work_reg(work_reg),
        .flag_reg(flag_reg));
    daf_mem u_daf_mem (.sys_clk(sys_clk), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // Far above the hundred or so cycles the tests need
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic run_op(input daf_op_t x);
        rd_n = 0;
        wr_n = 0;
        op <= x;
        op_valid <= 1'b1;
        // Hold the request until the core shows ready at an edge
        do begin
            @(posedge sys_clk);
        end while (op_ready !== 1'b1);
        op_valid <= 1'b0;
        do begin
            @(negedge sys_clk);
            if (rd_en === 1'b1) begin
                rd_a = rd_addr;
                rd_n++;
            end
            if (wr_en === 1'b1) begin
                {wr_a, wr_d} = {wr_addr, wr_data};
                wr_n++;
            end
            if (jump_valid === 1'b1) begin
                jt = jump_target;
            end
        end while (op_done !== 1'b1);
        @(posedge sys_clk);
    endtask : run_op

    function automatic daf_op_t mk(daf_mode_t m, daf_alu_t f, logic a, logic d, logic [7:0] fa);
        mk = '0;
        mk.mode = m;
        mk.alu = f;
        mk.access_sel = a;
        mk.dest_sel = d;
        mk.file_addr = fa;
    endfunction : mk

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, op_valid, op} = '0;
        rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        u_daf_mem.mem[12'h210] = 8'h7f;
        u_daf_mem.mem[12'h020] = 8'h01;
        u_daf_mem.mem[12'hf90] = 8'h88;
        u_daf_mem.mem[12'hf91] = 8'h10;
        u_daf_mem.mem[12'h123] = 8'h3c;
        @(posedge sys_clk);
        apb(1'b0, REG_FLAGS, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b1, REG_FLAGS, 32'hff);
        apb(1'b0, REG_FLAGS, 32'h0);
        chk(rdat, 32'h1f);
        apb(1'b0, 12'h0fc, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        apb(1'b1, REG_FLAGS, 32'h0);
        apb(1'b1, REG_BANK, 32'h2);
        apb(1'b1, REG_WORK, 32'h1);
        apb(1'b1, REG_PTR_LO0, 32'hff);
        apb(1'b1, REG_PTR_LO0 + 2 * REG_PTR_STEP, 32'h40);
        $display("test registers done");
        run_op(mk(DAF_M_DIRECT, DAF_A_ADD, 1'b1, 1'b1, 8'h10));
        chk(rd_a, 12'h210);
        chk({wr_a, wr_d}, {12'h210, 8'h80});
        chk(flag_reg, 8'h1a);
        run_op(mk(DAF_M_DIRECT, DAF_A_SUB, 1'b0, 1'b0, 8'h20));
        chk(rd_a, 12'h020);
        chk(wr_n, 0);
        chk(work_reg, 8'h00);
        chk(flag_reg, 8'h07);
        run_op(mk(DAF_M_DIRECT, DAF_A_ROTL, 1'b0, 1'b1, 8'h90));
        chk({wr_a, wr_d}, {12'hf90, 8'h11});
        chk(flag_reg, 8'h03);
        run_op(mk(DAF_M_DIRECT, DAF_A_ROTR, 1'b0, 1'b1, 8'h91));
        chk({wr_a, wr_d}, {12'hf91, 8'h88});
        chk(flag_reg, 8'h12);
        o = mk(DAF_M_MOVE, DAF_A_NONE, 1'b1, 1'b0, 8'h00);
        o.move_src = 12'h123;
        o.move_dst = 12'h456;
        run_op(o);
        chk({rd_a, wr_a, wr_d}, {12'h123, 12'h456, 8'h3c});
        chk(flag_reg, 8'h12);
        $display("test direct done");
        apb(1'b1, REG_WORK, 32'hff);
        for (int i = 0; i < 5; i++) begin
            o = mk(DAF_M_INDIRECT, DAF_A_PASS, 1'b1, 1'b1, 8'h00);
            o.ind = inds[i];
            run_op(o);
            chk(rd_a, adrs[i]);
        end
        apb(1'b0, REG_PTR_LO0, 32'h0);
        chk(rdat, 32'h00);
        apb(1'b0, REG_PTR_HI0, 32'h0);
        chk(rdat, 32'h01);
        $display("test indirect done");
        o = mk(DAF_M_JUMP, DAF_A_NONE, 1'b0, 1'b0, 8'h00);
        o.jump_target = 20'habcde;
        run_op(o);
        chk(jt, 20'habcde);
        run_op(mk(DAF_M_INHERENT, DAF_A_NONE, 1'b0, 1'b0, 8'h00));
        chk(rd_n, 0);
        apb(1'b1, REG_FLAGS, 32'h01);
        run_op(mk(DAF_M_DIRECT, DAF_A_ADD, 1'b0, 1'b1, FLAG_DADDR[7:0]));
        chk(wr_n, 0);
        chk(flag_reg, 8'h07);
        o = mk(DAF_M_LITERAL, DAF_A_ADD, 1'b0, 1'b0, 8'h00);
        o.literal = 8'h10;
        run_op(o);
        chk({work_reg, flag_reg}, 16'h0f01);
        chk(rd_n, 0);
        apb(1'b1, REG_CFG, 32'h1);
        run_op(mk(DAF_M_DIRECT, DAF_A_PASS, 1'b0, 1'b0, 8'h05));
        chk(rd_a, 12'h045);
        $display("test misc done");
        tally_and_finish();
    end
endmodule : tb_daf_core

`default_nettype wire
